//--- rtl/odgq_pkg.sv
// Package with constants and carrier types for the open-drain pin quad
package odgq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ODGQ_ADDR_CTRL  = 8'h0F;
  localparam logic [7:0] ODGQ_ADDR_PINS  = 8'h10;
  localparam logic [7:0] ODGQ_RST_CTRL   = 8'h00;
  localparam logic [7:0] ODGQ_RST_PINS   = 8'h00;
  localparam int         ODGQ_NPINS      = 4;
  localparam int         ODGQ_DIR_LSB    = 4;
  localparam int         ODGQ_LVL_LSB    = 0;
  localparam int         ODGQ_EDGE_LSB   = 4;
  localparam int         ODGQ_MASK_LSB   = 0;
  localparam int         ODGQ_SYNC_STAGES = 2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odgq_req_type;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [7:0] rdata;
  } odgq_rsp_type;

endpackage

//--- rtl/odgq_sync.sv
// Multi-bit two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module odgq_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

//--- rtl/odgq_top.sv
// Four open-drain pins with direction, level, edge and mask registers
`timescale 1ns/1ps
module odgq_top
  import odgq_pkg::*;
#(
  parameter int NPINS = 4
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  // Register access from the serial interface logic
  input  wire odgq_pkg::odgq_req_type req_i,
  output odgq_pkg::odgq_rsp_type      rsp_o,
  // Pins: level in, driven level out, output enable (low drives)
  input  wire logic [NPINS-1:0]       pin_i,
  output logic      [NPINS-1:0]       pin_o,
  output logic      [NPINS-1:0]       pin_oe_n_o,
  // Per-pin interrupt event pulses
  output logic      [NPINS-1:0]       pin_event_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [NPINS-1:0] dir_ff;
  logic [NPINS-1:0] lvl_ff;
  logic [NPINS-1:0] edge_ff;
  logic [NPINS-1:0] mask_ff;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] pin_prev_ff;
  logic [NPINS-1:0] event_ff;
  odgq_rsp_type     rsp_ff;
  logic             wr_pins;
  logic             wr_ctrl;

  assign wr_pins = req_i.wr && (req_i.addr == ODGQ_ADDR_PINS);
  assign wr_ctrl = req_i.wr && (req_i.addr == ODGQ_ADDR_CTRL);

  // Pins are asynchronous; nothing looks at them before two flops
  odgq_sync #(
    .WIDTH   (NPINS)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // ****************************************************************
  // Direction and level register
  // ****************************************************************
  // Directions from the upper nibble; reset leaves every pin an input
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_ff <= ODGQ_RST_PINS[ODGQ_DIR_LSB +: NPINS];
    end else if (wr_pins) begin
      dir_ff <= req_i.wdata[ODGQ_DIR_LSB +: NPINS];
    end
  end

  // Level bits: input pins track the pin, output pins take writes
  // The new direction applies, so a pin turned to output takes its level
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_lvl
      logic nxt_dir;
      assign nxt_dir = wr_pins ? req_i.wdata[ODGQ_DIR_LSB + g] : dir_ff[g];
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          lvl_ff[g] <= ODGQ_RST_PINS[ODGQ_LVL_LSB + g];
        end else if (!nxt_dir) begin
          lvl_ff[g] <= pin_sync[g];
        end else if (wr_pins) begin
          lvl_ff[g] <= req_i.wdata[ODGQ_LVL_LSB + g];
        end
      end
    end
  endgenerate

  // Open drain: only ever pull low, never drive high
  assign pin_o      = '0;
  assign pin_oe_n_o = ~(dir_ff & lvl_ff);

  // ****************************************************************
  // Edge select and mask register
  // ****************************************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_ff <= ODGQ_RST_CTRL[ODGQ_EDGE_LSB +: NPINS];
      mask_ff <= ODGQ_RST_CTRL[ODGQ_MASK_LSB +: NPINS];
    end else if (wr_ctrl) begin
      edge_ff <= req_i.wdata[ODGQ_EDGE_LSB +: NPINS];
      mask_ff <= req_i.wdata[ODGQ_MASK_LSB +: NPINS];
    end
  end

  // ****************************************************************
  // Edge detection on synchronised input pins
  // ****************************************************************
  // Output pins raise no events; the mask blocks the event at source
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_prev_ff <= '0;
      event_ff    <= '0;
    end else begin
      pin_prev_ff <= pin_sync;
      event_ff    <= ~dir_ff & ~mask_ff &
                     ((edge_ff & pin_sync & ~pin_prev_ff) |
                      (~edge_ff & ~pin_sync & pin_prev_ff));
    end
  end

  assign pin_event_o = event_ff;

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped addresses answer with hit low and zero data
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= req_i.rd;
      rsp_ff.hit   <= req_i.rd && ((req_i.addr == ODGQ_ADDR_PINS) ||
                                   (req_i.addr == ODGQ_ADDR_CTRL));
      if (req_i.rd && req_i.addr == ODGQ_ADDR_PINS) begin
        rsp_ff.rdata <= {dir_ff, lvl_ff};
      end else if (req_i.rd && req_i.addr == ODGQ_ADDR_CTRL) begin
        rsp_ff.rdata <= {edge_ff, mask_ff};
      end else begin
        rsp_ff.rdata <= 8'h00;
      end
    end
  end

  assign rsp_o = rsp_ff;

endmodule

//--- tb/odgq_pullup.sv
// Pull-up resistors and attached logic outside the pin quad
`timescale 1ns/1ps
module odgq_pullup (
  // From the device and the bench
  input  wire logic [3:0] oe_n_i,
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] ext_low_i,
  // Resolved pin level
  output logic      [3:0] pin_o
);
  // Pull-up wins unless the pull-down or outside logic sinks the pin
  assign pin_o = (oe_n_i | drive_i) & ~ext_low_i;
endmodule

//--- tb/odgq_top_asserts.sv
// Port checks for the open-drain pin quad
`timescale 1ns/1ps
module odgq_top_asserts
  import odgq_pkg::*;
#(parameter int NPINS = 4) (
  // Watched ports
  input wire logic                   clock_i,
  input wire logic                   nrst_i,
  input wire odgq_pkg::odgq_req_type req_i,
  input wire odgq_pkg::odgq_rsp_type rsp_o,
  input wire logic [NPINS-1:0]       pin_i,
  input wire logic [NPINS-1:0]       pin_o,
  input wire logic [NPINS-1:0]       pin_oe_n_o,
  input wire logic [NPINS-1:0]       pin_event_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Five quiet samples cover both sync stages plus the output register
  sequence s_quiet;
    $stable(pin_i)[*5];
  endsequence
  logic pins_rd;
  logic bad_addr;
  assign pins_rd = req_i.rd && req_i.addr == ODGQ_ADDR_PINS;
  assign bad_addr = req_i.addr != ODGQ_ADDR_PINS && req_i.addr != 8'h0F;
  a_open_drain: assert property (pin_o == '0)
    else $error("pin driven high");
  a_write_drive: assert property (req_i.wr && req_i.addr == ODGQ_ADDR_PINS
    |=> pin_oe_n_o == ~($past(req_i.wdata[7:4]) & $past(req_i.wdata[3:0])))
    else $error("pull-down not per write");
  a_hold_drive: assert property (!(req_i.wr && !bad_addr) |=>
    $stable(pin_oe_n_o)) else $error("drive moved");
  a_read_valid: assert property (req_i.rd |=> rsp_o.valid)
    else $error("no read answer");
  a_no_answer: assert property (!req_i.rd |=> !rsp_o.valid)
    else $error("stray answer");
  a_unmapped_rd: assert property (req_i.rd && bad_addr |=>
    !rsp_o.hit && rsp_o.rdata == 8'h00) else $error("unmapped hit");
  a_input_level: assert property (s_quiet ##0 pins_rd |=> ((rsp_o.rdata[3:0]
    ^ $past(pin_i)) & ~rsp_o.rdata[7:4]) == '0)
    else $error("input level wrong");
  a_quiet_event: assert property (s_quiet |=> pin_event_o == '0)
    else $error("event without edge");
endmodule
bind odgq_top odgq_top_asserts #(.NPINS(NPINS)) i_odgq_top_asserts (
  .clock_i(clock_i), .nrst_i(nrst_i), .req_i(req_i), .rsp_o(rsp_o),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
  .pin_event_o(pin_event_o));

//--- tb/odgq_top_test.sv
// Self-checking bench for the open-drain pin quad
`timescale 1ns/1ps
module odgq_top_test;
  import odgq_pkg::*;
  logic         clock_i;
  logic         nrst_i;
  odgq_req_type req;
  odgq_rsp_type rsp;
  logic [3:0]   lvl, drv, oe_n, evt, ext_low;
  int           n_errors, tests_run, cycles;
  odgq_top i_odgq_top (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req),
    .rsp_o(rsp), .pin_i(lvl), .pin_o(drv), .pin_oe_n_o(oe_n),
    .pin_event_o(evt));
  odgq_pullup i_odgq_pullup (.oe_n_i(oe_n), .drive_i(drv),
    .ext_low_i(ext_low), .pin_o(lvl));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(posedge clock_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 chk({rsp.valid, rsp.hit, rsp.rdata}, {1'b1, h, d});
  endtask
  task automatic t_reset();
    repeat (6) @(posedge clock_i);
    rd(ODGQ_ADDR_PINS, 8'h0F, 1'b1);
    rd(ODGQ_ADDR_CTRL, 8'h00, 1'b1);
    rd(8'h11, 8'h00, 1'b0);
  endtask
  // Level writes to the two input pins must be dropped
  task automatic t_drive();
    wr(ODGQ_ADDR_PINS, 8'h35);
    #1 chk({6'h00, oe_n}, 10'h00E);
    repeat (5) @(posedge clock_i);
    rd(ODGQ_ADDR_PINS, 8'h3D, 1'b1);
    wr(ODGQ_ADDR_PINS, 8'h00);
  endtask
  task automatic t_edge(input int p, input logic [7:0] c,
                        input logic [1:0] e);
    logic [1:0] seen;
    seen = 2'b00;
    wr(ODGQ_ADDR_CTRL, c);
    ext_low[p] <= 1'b1;
    repeat (8) begin
      #1 seen[1] |= evt[p];
      @(posedge clock_i);
    end
    ext_low[p] <= 1'b0;
    repeat (8) begin
      #1 seen[0] |= evt[p];
      @(posedge clock_i);
    end
    chk({8'h00, seen}, {8'h00, e});
  endtask
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    req = '0;
    ext_low = 4'h0;
    nrst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_drive();
    t_edge(2, 8'h00, 2'b10);
    t_edge(0, 8'h10, 2'b01);
    t_edge(3, 8'h08, 2'b00);
    stop_test();
  end
endmodule
